/* src/chain_test_access_port.sv */
`include "tap_regs.svh"

module chain_test_access_port #(
  parameter int         BS_LEN     = `BSR_LEN,
  parameter logic [3:0]  ID_VERSION = `ID_VERSION,   // Arbitrary value
  parameter logic [5:0]  ID_FAMILY  = `ID_FAMILY,    // Arbitrary value
  parameter logic [6:0]  ID_ARRAY   = `ID_ARRAY,     // Arbitrary value
  parameter logic [10:0] ID_MAKER   = `ID_MAKER      // Arbitrary value
) (
  input  wire  logic                 mclk,
  input  wire  logic                 rst_n,
  // AHB-Lite slave
  input  wire  logic                 hsel,
  input  wire  logic [7:0]           haddr,
  input  wire  logic [1:0]           htrans,
  input  wire  logic                 hwrite,
  input  wire  logic [2:0]           hsize,
  input  wire  logic [31:0]          hwdata,
  input  wire  logic                 hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Test port pins
  input  wire  logic                 test_port_clock,
  input  wire  logic                 test_port_mode_select,
  input  wire  logic                 test_port_data_in,
  output logic                       test_port_data_out,
  // Other configuration sources, same clock domain
  input  wire  tap_pkg::jtag_t       card_jtag,
  input  wire  tap_pkg::jtag_t       host_jtag,
  // Configuration chain port
  output tap_pkg::jtag_t             config_chain_jtag_port,
  input  wire  logic                 config_chain_tdo,
  // Boundary-scan cells
  input  wire  logic [BS_LEN-1:0]    bs_pin_capture,
  output logic [BS_LEN-1:0]          bs_pin_drive,
  output logic                       bs_extest
);

  // ========================================================================
  // Elaboration checks
  // Shift paths need a head and a tail bit; the identity fields must fill one word
  generate
    if (BS_LEN < 2) begin : g_bad_len
      $error("boundary-scan length must be at least 2");
    end
    if ($bits(ID_VERSION) + $bits(ID_FAMILY) + $bits(ID_ARRAY) + $bits(ID_MAKER) + 4
        != `ID_LEN) begin : g_bad_id
      $error("identification fields do not fill one word");
    end
    if (`IR_LEN < 2) begin : g_bad_ir
      $error("instruction register must hold the two fixed capture bits");
    end
  endgenerate

  // ========================================================================
  // Pin synchronisers
  logic [1:0] tck_sync_ff;
  logic [1:0] tms_sync_ff;
  logic [1:0] tdi_sync_ff;
  logic [1:0] ctdo_sync_ff;
  logic       tck_prev_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tck_sync_ff  <= 2'h0;
      tms_sync_ff  <= 2'h3;
      tdi_sync_ff  <= 2'h0;
      ctdo_sync_ff <= 2'h0;
      tck_prev_ff  <= 1'b0;
    end else begin
      tck_sync_ff  <= {tck_sync_ff[0], test_port_clock};
      tms_sync_ff  <= {tms_sync_ff[0], test_port_mode_select};
      tdi_sync_ff  <= {tdi_sync_ff[0], test_port_data_in};
      ctdo_sync_ff <= {ctdo_sync_ff[0], config_chain_tdo};
      tck_prev_ff  <= tck_sync_ff[1];
    end
  end

  // A stopped test clock simply yields no edges; the TAP holds its state.
  // The edge detector rests at the pin's idle low level, so reset makes no false edge
  wire tck_s    = tck_sync_ff[1];
  wire tms_s    = tms_sync_ff[1];
  wire tdi_s    = tdi_sync_ff[1];
  wire tck_rise = tck_s & ~tck_prev_ff;
  wire tck_fall = ~tck_s & tck_prev_ff;

  // ========================================================================
  // TAP controller
  tap_pkg::tap_state_t state_ff;
  tap_pkg::tap_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tap_pkg::TLR:    nxt_state = tms_s ? tap_pkg::TLR    : tap_pkg::RTI;
      tap_pkg::RTI:    nxt_state = tms_s ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_DR: nxt_state = tms_s ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
      tap_pkg::CAP_DR: nxt_state = tms_s ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::SH_DR:  nxt_state = tms_s ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
      tap_pkg::EX1_DR: nxt_state = tms_s ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
      tap_pkg::PAU_DR: nxt_state = tms_s ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
      tap_pkg::EX2_DR: nxt_state = tms_s ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
      tap_pkg::UPD_DR: nxt_state = tms_s ? tap_pkg::SEL_DR : tap_pkg::RTI;
      tap_pkg::SEL_IR: nxt_state = tms_s ? tap_pkg::TLR    : tap_pkg::CAP_IR;
      tap_pkg::CAP_IR: nxt_state = tms_s ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::SH_IR:  nxt_state = tms_s ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
      tap_pkg::EX1_IR: nxt_state = tms_s ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
      tap_pkg::PAU_IR: nxt_state = tms_s ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
      tap_pkg::EX2_IR: nxt_state = tms_s ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
      tap_pkg::UPD_IR: nxt_state = tms_s ? tap_pkg::SEL_DR : tap_pkg::RTI;
      default:         nxt_state = tap_pkg::TLR;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= tap_pkg::TLR;
    end else if (tck_rise) begin
      state_ff <= nxt_state;
    end
  end

  // ========================================================================
  // Instruction decode
  function automatic tap_pkg::instr_t decode(input logic [`IR_LEN-1:0] op);
    case (op)
      `OP_EXTEST: decode = tap_pkg::INS_EXTEST;
      `OP_SAMPLE: decode = tap_pkg::INS_SAMPLE;
      `OP_IDCODE: decode = tap_pkg::INS_IDCODE;
      `OP_BYPASS: decode = tap_pkg::INS_BYPASS;
      default:    decode = tap_pkg::INS_BYPASS;
    endcase
  endfunction : decode

  // ========================================================================
  // Register bus
  logic [1:0]  ctrl_ff;
  logic [5:0]  flags_ff;
  logic [7:0]  waddr_ff;
  logic        wpend_ff;
  logic [31:0] hrdata_ff;

  wire        addr_take = hsel & htrans[1] & hready;
  wire        word_ok   = (hsize == 3'h2) & (haddr[1:0] == 2'h0);
  wire        card_owns = ctrl_ff[`CTRL_CARD_BIT];
  wire        host_owns = ctrl_ff[`CTRL_HOST_BIT];
  wire        test_owns = ~card_owns & ~host_owns;

  logic [`IR_LEN-1:0] ir_ff;
  logic [`IR_LEN-1:0] ir_shift_ff;

  wire [31:0] rd_mux =
    (haddr == `OFS_CTRL)    ? {30'h0, ctrl_ff} :
    (haddr == `OFS_FLAGS)   ? {26'h0, flags_ff} :
    (haddr == `OFS_TAPSTAT) ? {19'h0, test_owns, ir_ff, 4'(state_ff)} :
    32'h0;

  // Read data is taken in the address phase, so the slave never inserts a wait
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waddr_ff  <= 8'h00;
      wpend_ff  <= 1'b0;
      hrdata_ff <= 32'h0;
    end else begin
      wpend_ff <= addr_take & hwrite & word_ok;
      if (addr_take) begin
        waddr_ff <= haddr;
      end
      if (addr_take & ~hwrite) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // Writes land at the end of the data phase, when hwdata stands
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff  <= `CTRL_RESET;
      flags_ff <= `FLAGS_RESET;
    end else if (wpend_ff) begin
      if (waddr_ff == `OFS_CTRL) begin
        ctrl_ff <= hwdata[1:0];
      end
      if (waddr_ff == `OFS_FLAGS) begin
        flags_ff <= hwdata[5:0];
      end
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ========================================================================
  // Instruction register
  wire [`IR_LEN-1:0] ir_capture = {flags_ff, `IR_CAPTURE_LOW};

  // Instruction that holds after the coming test clock rise
  wire [`IR_LEN-1:0] nxt_ir =
    (state_ff == tap_pkg::TLR)    ? `OP_IDCODE :
    (state_ff == tap_pkg::UPD_IR) ? ir_shift_ff :
    ir_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ir_ff       <= `OP_IDCODE;
      ir_shift_ff <= `IR_LEN'h0;
    end else if (tck_rise) begin
      ir_ff <= nxt_ir;
      case (state_ff)
        tap_pkg::CAP_IR: ir_shift_ff <= ir_capture;
        tap_pkg::SH_IR:  ir_shift_ff <= {tdi_s, ir_shift_ff[`IR_LEN-1:1]};
        default:         ir_shift_ff <= ir_shift_ff;
      endcase
    end
  end

  wire tap_pkg::instr_t ins = decode(ir_ff);

  // ========================================================================
  // Data registers
  logic [BS_LEN-1:0]  bsr_ff;
  logic [BS_LEN-1:0]  bs_upd_ff;
  logic [`ID_LEN-1:0] id_ff;
  logic               byp_ff;
  logic               extest_ff;

  // Family and size fill only 13 of the 16 part-number bits; the spare top bits read zero
  wire [`ID_LEN-1:0] id_value = {ID_VERSION, 3'h0, ID_FAMILY, ID_ARRAY, ID_MAKER, 1'b1};
  wire sel_bsr = (ins == tap_pkg::INS_EXTEST) | (ins == tap_pkg::INS_SAMPLE);
  wire sel_id  = (ins == tap_pkg::INS_IDCODE);
  // Decoded from the incoming instruction so the pins switch at Update-IR,
  // even when the tester stops the clock right after it
  wire ext_next = (nxt_state != tap_pkg::TLR) & (decode(nxt_ir) == tap_pkg::INS_EXTEST);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bsr_ff <= '0;
      id_ff  <= `ID_LEN'h0;
      byp_ff <= 1'b0;
    end else if (tck_rise) begin
      case (state_ff)
        tap_pkg::CAP_DR: begin
          bsr_ff <= sel_bsr ? bs_pin_capture : bsr_ff;
          id_ff  <= id_value;
          byp_ff <= 1'b0;
        end
        tap_pkg::SH_DR: begin
          if (sel_bsr) begin
            bsr_ff <= {tdi_s, bsr_ff[BS_LEN-1:1]};
          end
          if (sel_id) begin
            id_ff <= {tdi_s, id_ff[`ID_LEN-1:1]};
          end
          byp_ff <= tdi_s;
        end
        tap_pkg::UPD_DR: byp_ff <= 1'b0;
        default:         byp_ff <= byp_ff;
      endcase
    end
  end

  // Preload and extest both update the drive latch; pins follow it only in extest
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bs_upd_ff <= '0;
      extest_ff <= 1'b0;
    end else if (tck_rise) begin
      extest_ff <= ext_next;
      if (state_ff == tap_pkg::UPD_DR && sel_bsr) begin
        bs_upd_ff <= bsr_ff;
      end
    end
  end

  assign bs_pin_drive = bs_upd_ff;
  assign bs_extest    = extest_ff;

  // ========================================================================
  // Serial output, changed on falling test clock
  wire in_sh_ir = (state_ff == tap_pkg::SH_IR);
  wire dr_bit   = sel_bsr ? bsr_ff[0] : sel_id ? id_ff[0] : byp_ff;
  wire own_bit  = in_sh_ir ? ir_shift_ff[0] : dr_bit;

  logic own_tdo_ff;

  // Outside the shift states the bit is a don't-care, so it is not gated
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      own_tdo_ff <= 1'b0;
    end else if (tck_fall) begin
      own_tdo_ff <= own_bit;
    end
  end

  // ========================================================================
  // Configuration chain multiplexer
  tap_pkg::jtag_t chain_ff;
  logic           tdo_ff;

  // Own TAP sits first in the chain; chain return feeds the test port.
  wire tap_pkg::jtag_t test_src = '{tck: tck_s, tms: tms_s, tdi: own_tdo_ff};
  // Card wins when software hands the chain to both sources
  wire tap_pkg::jtag_t chain_sel =
    card_owns ? card_jtag : host_owns ? host_jtag : test_src;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chain_ff <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};
      tdo_ff   <= 1'b0;
    end else begin
      chain_ff <= chain_sel;
      tdo_ff   <= test_owns ? ctdo_sync_ff[1] : own_tdo_ff;
    end
  end

  // The chain clock lags the test pin by three system clocks (synchroniser and chain register), same frequency
  // The tester sees the whole chain only while the test port owns it
  assign config_chain_jtag_port = chain_ff;
  assign test_port_data_out     = tdo_ff;

endmodule : chain_test_access_port

/* src/tap_pkg.sv */
package tap_pkg;

  // ========================================================================
  // Three JTAG drive lines of one source
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_t;

  // ========================================================================
  // Standard sixteen-state controller
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  typedef enum logic [1:0] {
    INS_BYPASS, INS_SAMPLE, INS_EXTEST, INS_IDCODE
  } instr_t;

endpackage : tap_pkg

/* src/tap_regs.svh */
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// ==========================================================================
// Register map (byte addresses on the AHB-Lite slave)
`define OFS_CTRL          8'h00
`define OFS_FLAGS         8'h04
`define OFS_TAPSTAT       8'h08
`define CTRL_CARD_BIT     0
`define CTRL_HOST_BIT     1
`define CTRL_RESET        2'h0
`define FLAGS_RESET       6'h00

// ==========================================================================
// Instruction register
`define IR_LEN            8
`define IR_CAPTURE_LOW    2'h1
`define OP_EXTEST         8'h00
`define OP_SAMPLE         8'h01
`define OP_IDCODE         8'h09
`define OP_BYPASS         8'hFF

// ==========================================================================
// Data registers
`define BSR_LEN           109
`define ID_LEN            32
`define ID_VERSION        4'h2
`define ID_FAMILY         6'h15
`define ID_ARRAY          7'h2A
`define ID_MAKER          11'h2B5

`endif

/* verification/chain_test_access_port_tb.sv */
`include "tap_regs.svh"

module chain_test_access_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int  BS = 12;
  localparam int  LIMIT = 6000;
  logic           mclk = 1'b0;
  logic           rst_n = 1'b0;
  logic           hsel = 1'b0;
  logic [7:0]     haddr = 8'h00;
  logic [1:0]     htrans = 2'h0;
  logic           hwrite = 1'b0;
  logic [31:0]    hwdata = 32'h0;
  logic [31:0]    hrdata, r, q, d;
  logic           hreadyout, hresp, tdo, extest, tck, tms, tdi;
  logic           chain_ret = 1'b0;
  tap_pkg::jtag_t card = '0, host = '0, chain;
  logic [BS-1:0]  cap = '0, drv;
  logic [7:0]     op;
  int             seed = 41765;
  int             n_errors = 0;
  int             cmp_count = 0;
  int             cyc = 0;

  chain_test_access_port #(.BS_LEN(BS)) dut_u (.mclk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .test_port_clock(tck), .test_port_mode_select(tms), .test_port_data_in(tdi),
    .test_port_data_out(tdo), .card_jtag(card), .host_jtag(host),
    .config_chain_jtag_port(chain), .config_chain_tdo(chain_ret),
    .bs_pin_capture(cap), .bs_pin_drive(drv), .bs_extest(extest));
  jtag_tester tst (.tck, .tms, .tdi, .tdo);

  initial forever #25 mclk = ~mclk;

  // ==========
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Version on top, three spare part-number bits, then family, size, maker, one
  function automatic logic [31:0] id_expect();
    id_expect = {`ID_VERSION, 3'h0, `ID_FAMILY, `ID_ARRAY, `ID_MAKER, 1'b1};
  endfunction : id_expect

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dw,
                     output logic [31:0] dr);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dw;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    dr = hrdata;
  endtask : ahb

  // From idle, through capture and shift, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] di,
                      output logic [31:0] dq);
    logic b;
    dq = '0;
    tst.bit_io(1'b1, 1'b0, b);
    if (ir) tst.bit_io(1'b1, 1'b0, b);
    tst.bit_io(1'b0, 1'b0, b);
    tst.bit_io(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tst.bit_io(i == n - 1, di[i], b);
      dq[i] = b;
    end
    tst.bit_io(1'b1, 1'b0, b);
    tst.bit_io(1'b0, 1'b0, b);
  endtask : scan

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      results();
    end
  end

  // ==========
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int o = 3; o >= 0; o--) begin
      card <= 3'($random(seed));
      host <= 3'($random(seed));
      chain_ret <= 1'($random(seed));
      ahb(1'b1, `OFS_CTRL, 32'(o), r);
      repeat (5) @(posedge mclk);
      chk(32'(chain), 32'(o[0] ? card : o[1] ? host : {tck, tms, 1'b0}));
      chk(32'(tdo), 32'(o == 0 ? chain_ret : 1'b0));
      ahb(1'b0, `OFS_TAPSTAT, 32'h0, r);
      chk(32'(r[12]), 32'(o == 0));
    end
    // Reset by held mode select while the test port drives the chain
    for (int k = 0; k < 5; k++) tst.bit_io(1'b1, 1'b0, q[0]);
    tst.bit_io(1'b0, 1'b0, q[0]);
    ahb(1'b1, `OFS_CTRL, 32'h1, r);
    d = 32'($random(seed)) & 32'h3F;
    ahb(1'b1, `OFS_FLAGS, d, r);
    ahb(1'b0, `OFS_FLAGS, 32'h0, r);
    chk(r, d);
    ahb(1'b0, 8'h1C, 32'h0, r);
    chk(r, 32'h0);
    scan(1'b0, 32, 32'h0, q);
    chk(q, id_expect());
    scan(1'b1, `IR_LEN, 32'(`OP_SAMPLE), q);
    chk(q, {24'h0, d[5:0], `IR_CAPTURE_LOW});
    @(posedge mclk);
    cap <= BS'($random(seed));
    d = 32'(BS'($random(seed)));
    scan(1'b0, BS, d, q);
    chk(q, 32'(cap));
    chk(32'(drv), d);
    chk(32'(extest), 32'h0);
    scan(1'b1, `IR_LEN, 32'(`OP_EXTEST), q);
    chk(32'(extest), 32'h1);
    for (int k = 0; k < 2; k++) begin
      op = k ? `OP_BYPASS : 8'h02 + 8'($random(seed) & 3);
      scan(1'b1, `IR_LEN, 32'(op), q);
      d = 32'($random(seed)) & 32'hFF;
      scan(1'b0, 8, d, q);
      chk(q, {24'h0, d[6:0], 1'b0});
    end
    chk(32'(extest), 32'h0);
    scan(1'b1, `IR_LEN, 32'(`OP_IDCODE), q);
    scan(1'b0, 32, 32'h0, q);
    chk(q, id_expect());
    results();
  end
endmodule : chain_test_access_port_tb

/* verification/jtag_tester.sv */
// ==========
// Tester at the test port
module jtag_tester (
  output logic tck,
  output logic tms,
  output logic tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tck <= 1'b0;
    tms <= 1'b1;
    tdi <= 1'b0;
  end
  // Clock stands low between frames; TDO is taken late in the high phase
  // Pins move by non-blocking assignment, as calls start on a system clock edge
  task automatic bit_io(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    #200 tck <= 1'b1;
    #190 q = tdo;
    #10 tck <= 1'b0;
  endtask : bit_io
endmodule : jtag_tester

/* verification/tap_chk.sv */
// ==========
// Port checker
module tap_chk (
  input wire logic           mclk,
  input wire logic           rst_n,
  input wire logic           hsel,
  input wire logic [7:0]     haddr,
  input wire logic [1:0]     htrans,
  input wire logic           hwrite,
  input wire logic [2:0]     hsize,
  input wire logic [31:0]    hwdata,
  input wire logic           hready,
  input wire logic [31:0]    hrdata,
  input wire logic           hreadyout,
  input wire logic           hresp,
  input wire logic           test_port_clock,
  input wire logic           test_port_mode_select,
  input wire logic           test_port_data_out,
  input wire tap_pkg::jtag_t card_jtag,
  input wire tap_pkg::jtag_t host_jtag,
  input wire tap_pkg::jtag_t config_chain_jtag_port
);
  logic [1:0] own_ff;
  logic [5:0] flg_ff;
  logic       wr_ff;
  logic [7:0] adr_ff;
  logic [2:0] up_ff;
  wire take = hsel & htrans[1] & hready;
  wire wok  = take & hwrite & (hsize == 3'h2) & (haddr[1:0] == 2'h0);
  wire none = (own_ff == 2'h0);
  wire rd   = take & !hwrite;
  // Mirror of the ownership and flag registers, taken from bus writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      own_ff <= 2'h0;
      flg_ff <= 6'h00;
      wr_ff  <= 1'b0;
      adr_ff <= 8'h00;
      up_ff  <= 3'h0;
    end else begin
      wr_ff  <= wok;
      adr_ff <= haddr;
      if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
      if (wr_ff && adr_ff == 8'h00) own_ff <= hwdata[1:0];
      if (wr_ff && adr_ff == 8'h04) flg_ff <= hwdata[5:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  okay_resp_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not zero-wait okay");
  flags_read_a: assert property (rd && haddr == 8'h04 |=> hrdata == {26'h0, $past(flg_ff)})
    else $error("flag readback wrong");
  unmapped_read_a: assert property (rd && haddr > 8'h08 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  card_route_a: assert property ($past(own_ff[0]) |-> config_chain_jtag_port == $past(card_jtag))
    else $error("chain not following card source");
  host_route_a: assert property ($past(own_ff == 2'h2) |-> config_chain_jtag_port == $past(host_jtag))
    else $error("chain not following host source");
  test_route_a: assert property (up_ff == 3'h7 && $past(none)
    |-> config_chain_jtag_port.tms == $past(test_port_mode_select, 3))
    else $error("chain not following test port");
  test_clock_a: assert property (up_ff == 3'h7 && $past(none)
    |-> config_chain_jtag_port.tck == $past(test_port_clock, 3))
    else $error("chain clock not following test clock");
  tdo_fall_a: assert property (own_ff[0] && $past(own_ff[0], 3) && $changed(test_port_data_out)
    |-> !$past(test_port_clock, 3))
    else $error("test output moved away from a falling clock");
endmodule : tap_chk

bind chain_test_access_port tap_chk chk_u (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .test_port_clock,
  .test_port_mode_select, .test_port_data_out, .card_jtag, .host_jtag, .config_chain_jtag_port);
